// File: rtl/qtc_pkg.sv
// qtc_pkg: constants and carrier types for the qualified trace and cache gate
// assumes a 32-bit processor bus whose 3 function-code lines give the space
package qtc_pkg;

	// ----------------------------------------------------------------
	// widths and sizes
	// ----------------------------------------------------------------
	localparam int QTC_ADDR_W = 32;
	localparam int QTC_DATA_W = 32;
	localparam int QTC_FC_W = 3;
	localparam int QTC_STRB_W = 4;
	// trace memory holds cycle numbers 0 .. 7FF
	localparam int QTC_TRACE_DEPTH = 2048;
	localparam int QTC_FIFO_DEPTH = 32;

	// ----------------------------------------------------------------
	// reset values and limits
	// ----------------------------------------------------------------
	localparam logic [QTC_ADDR_W-1:0] QTC_BOUND_RST = 32'h0000_0000;
	localparam logic QTC_QUAL_RST = 1'b0;
	localparam logic QTC_GO_CACHE_RST = 1'b0;
	// prefetch makes a narrower region lose fetches
	localparam logic [QTC_ADDR_W-1:0] QTC_MIN_SPAN_BYTES = 32'h0000_0014;

	// ----------------------------------------------------------------
	// function-code decode
	// ----------------------------------------------------------------
	localparam logic [QTC_FC_W-1:0] QTC_FC_USER_PROG = 3'h2;
	localparam logic [QTC_FC_W-1:0] QTC_FC_SUPER_PROG = 3'h6;
	localparam int QTC_FC_SUPER_BIT = 2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		QTC_SPC_USER = 2'b01,
		QTC_SPC_SUPER = 2'b10,
		QTC_SPC_BOTH = 2'b11
	} qtc_space_e;

	typedef enum logic {
		QTC_CAP_IDLE = 1'b0,
		QTC_CAP_RUN = 1'b1
	} qtc_cap_e;

	typedef struct packed {
		logic [QTC_ADDR_W-1:0] addr;
		logic [QTC_DATA_W-1:0] data;
		logic [QTC_FC_W-1:0] fc;
		logic rw;
		logic [QTC_STRB_W-1:0] strb;
	} qtc_cycle_s;

	typedef struct packed {
		logic qualEn;
		qtc_space_e space;
		logic [QTC_ADDR_W-1:0] start;
		logic [QTC_ADDR_W-1:0] endBound;
	} qtc_cfg_s;

	localparam qtc_cfg_s QTC_CFG_RST = '{
		qualEn: QTC_QUAL_RST,
		space: QTC_SPC_BOTH,
		start: QTC_BOUND_RST,
		endBound: QTC_BOUND_RST
	};

endpackage

// File: rtl/qtc_fifo.sv
// qtc_fifo: synchronous valid/ready fifo between capture and trace memory
// assumes one clock, synchronous active-low reset, power-of-two depth
`timescale 1ns/1ns
`default_nettype none

module qtc_fifo
	import qtc_pkg::*;
#(
	parameter int WIDTH = $bits(qtc_cycle_s),
	parameter int DEPTH = QTC_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int PTR_W = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : gBadFifo
		$error("fifo depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W:0] wp_reg, wp_next, rp_reg, rp_next;
	logic push, pop;

	// ----------------------------------------------------------------
	// pointers: extra top bit tells full from empty
	// ----------------------------------------------------------------
	always_comb begin
		inReady = (wp_reg[PTR_W] == rp_reg[PTR_W]) ||
			(wp_reg[PTR_W-1:0] != rp_reg[PTR_W-1:0]);
		outValid = wp_reg != rp_reg;
		push = inValid && inReady;
		pop = outValid && outReady;
		wp_next = push ? wp_reg + 1'b1 : wp_reg;
		rp_next = pop ? rp_reg + 1'b1 : rp_reg;
		outData = mem[rp_reg[PTR_W-1:0]];
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wp_reg <= '0;
			rp_reg <= '0;
		end else begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
		end
	end

	// storage carries no reset; only the pointers say what is valid
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_reg[PTR_W-1:0]] <= inData;
		end
	end

endmodule

`default_nettype wire

// File: rtl/qtc_trace_gate.sv
// qtc_trace_gate: qualified trace capture and processor cache gate
// assumes bus cycle inputs synchronous to clk and one record per busValid
`timescale 1ns/1ns
`default_nettype none

module qtc_trace_gate
	import qtc_pkg::*;
#(
	parameter int TRACE_DEPTH = QTC_TRACE_DEPTH,
	parameter int FIFO_DEPTH = QTC_FIFO_DEPTH,
	localparam int IDX_W = $clog2(TRACE_DEPTH)
) (
	input wire logic clk,
	input wire logic resetn,
	// configuration load
	input wire logic cfgWrite,
	input wire logic cfgQualEnable,
	input wire qtc_space_e cfgSpace,
	input wire logic [QTC_ADDR_W-1:0] cfgStart,
	input wire logic [QTC_ADDR_W-1:0] cfgEnd,
	input wire logic cfgEndIsOffset,
	output logic spanWarn,
	// run control and cache inputs and outputs
	input wire logic runStart,
	input wire logic runStop,
	input wire logic runCacheEnable,
	input wire logic targetCacheEnable,
	input wire logic cacheCtrlBit0,
	output logic cacheEnable,
	output logic inRegion,
	output logic capturing,
	// monitored bus
	input wire logic busValid,
	input wire qtc_cycle_s busCycle,
	output logic captureReady,
	// trace memory access
	input wire logic traceClear,
	input wire logic traceHold,
	input wire logic [IDX_W-1:0] rdIndex,
	output qtc_cycle_s rdData,
	output logic [IDX_W-1:0] wrIndex,
	output logic traceWrapped,
	output logic overflow
);
	localparam int REC_W = $bits(qtc_cycle_s);

	if (TRACE_DEPTH < 2 || (TRACE_DEPTH & (TRACE_DEPTH - 1)) != 0) begin : gBadDepth
		$error("TRACE_DEPTH must be a power of two of at least 2");
	end

	function automatic logic isProgFetch(input logic [QTC_FC_W-1:0] fc);
		isProgFetch = (fc == QTC_FC_USER_PROG) || (fc == QTC_FC_SUPER_PROG);
	endfunction

	function automatic logic spaceOk(input qtc_space_e sel, input logic [QTC_FC_W-1:0] fc);
		spaceOk = fc[QTC_FC_SUPER_BIT] ? sel[1] : sel[0];
	endfunction

	// ----------------------------------------------------------------
	// region configuration
	// ----------------------------------------------------------------
	qtc_cfg_s cfg_reg, cfg_next;
	logic spanWarn_reg, spanWarn_next;
	logic [QTC_ADDR_W-1:0] endCalc;

	always_comb begin
		endCalc = cfgEndIsOffset ? cfgStart + cfgEnd : cfgEnd;
		cfg_next = cfg_reg;
		spanWarn_next = spanWarn_reg;
		if (cfgWrite) begin
			cfg_next.qualEn = cfgQualEnable;
			cfg_next.space = cfgSpace;
			cfg_next.start = cfgStart;
			cfg_next.endBound = endCalc;
			// advisory only: a short span still works, it just misses fetches
			spanWarn_next = cfgQualEnable &&
				(endCalc < cfgStart || endCalc - cfgStart < QTC_MIN_SPAN_BYTES);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfg_reg <= QTC_CFG_RST;
			spanWarn_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			spanWarn_reg <= spanWarn_next;
		end
	end

	// ----------------------------------------------------------------
	// qualification and capture
	// ----------------------------------------------------------------
	qtc_cap_e cap_reg, cap_next;
	logic region_reg, region_next;
	logic qualOn, fetchNow, hitNow, storeNow;
	logic fifoInReady, fifoOutValid, fifoOutReady;
	logic [REC_W-1:0] fifoOutData;

	always_comb begin
		qualOn = cfg_reg.qualEn;
		fetchNow = busValid && isProgFetch(busCycle.fc);
		hitNow = busCycle.addr >= cfg_reg.start &&
			busCycle.addr <= cfg_reg.endBound &&
			spaceOk(cfg_reg.space, busCycle.fc);
		// data cycles inherit the verdict of the fetch that preceded them
		region_next = fetchNow ? hitNow : region_reg;
		cap_next = cap_reg;
		unique case (cap_reg)
			QTC_CAP_IDLE: begin
				if (runStart) begin
					cap_next = QTC_CAP_RUN;
				end
			end
			QTC_CAP_RUN: begin
				if (runStop) begin
					cap_next = QTC_CAP_IDLE;
				end
			end
		endcase
		storeNow = cap_reg == QTC_CAP_RUN && busValid && (!qualOn || region_next);
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cap_reg <= QTC_CAP_IDLE;
			region_reg <= 1'b0;
		end else begin
			cap_reg <= cap_next;
			region_reg <= region_next;
		end
	end

	// the bus cannot stall, so a full fifo drops the cycle and flags overflow
	qtc_fifo #(
		.WIDTH(REC_W),
		.DEPTH(FIFO_DEPTH)
	) uFifo (
		.clk(clk),
		.resetn(resetn),
		.inValid(storeNow),
		.inData(busCycle),
		.inReady(fifoInReady),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady),
		.outData(fifoOutData)
	);

	// ----------------------------------------------------------------
	// cache gate
	// ----------------------------------------------------------------
	logic goCache_reg, goCache_next, cacheEn_reg, cacheEn_next;

	always_comb begin
		goCache_next = runStart ? runCacheEnable : goCache_reg;
		cacheEn_next = goCache_next && targetCacheEnable && cacheCtrlBit0 &&
			!(qualOn && region_next);
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			goCache_reg <= QTC_GO_CACHE_RST;
			cacheEn_reg <= 1'b0;
		end else begin
			goCache_reg <= goCache_next;
			cacheEn_reg <= cacheEn_next;
		end
	end

	// ----------------------------------------------------------------
	// trace memory
	// ----------------------------------------------------------------
	qtc_cycle_s traceMem [TRACE_DEPTH];
	qtc_cycle_s rd_reg, rd_next;
	logic [IDX_W-1:0] wr_reg, wr_next, writeAddr;
	logic wrapped_reg, wrapped_next, ovf_reg, ovf_next, memWrite;

	always_comb begin
		fifoOutReady = !traceHold;
		memWrite = fifoOutValid && fifoOutReady;
		// a write in the clear cycle lands at cycle 0 and is kept
		writeAddr = traceClear ? '0 : wr_reg;
		wr_next = traceClear ? '0 : wr_reg;
		wrapped_next = traceClear ? 1'b0 : wrapped_reg;
		ovf_next = traceClear ? 1'b0 : ovf_reg;
		if (memWrite) begin
			wr_next = writeAddr + 1'b1;
			if (writeAddr == {IDX_W{1'b1}}) begin
				wrapped_next = 1'b1;
			end
		end
		if (storeNow && !fifoInReady) begin
			ovf_next = 1'b1;
		end
		rd_next = traceMem[rdIndex];
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wr_reg <= '0;
			wrapped_reg <= 1'b0;
			ovf_reg <= 1'b0;
			rd_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			wrapped_reg <= wrapped_next;
			ovf_reg <= ovf_next;
			rd_reg <= rd_next;
		end
	end

	always_ff @(posedge clk) begin
		if (memWrite) begin
			traceMem[writeAddr] <= qtc_cycle_s'(fifoOutData);
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_comb begin
		spanWarn = spanWarn_reg;
		cacheEnable = cacheEn_reg;
		inRegion = region_reg;
		capturing = cap_reg == QTC_CAP_RUN;
		captureReady = fifoInReady;
		rdData = rd_reg;
		wrIndex = wr_reg;
		traceWrapped = wrapped_reg;
		overflow = ovf_reg;
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence outsideFetchS;
		busValid && qualOn && isProgFetch(busCycle.fc) && !hitNow;
	endsequence

	sequence enterRegionS;
		qualOn && region_next;
	endsequence

	sequence goOffS;
		runStart && !runCacheEnable;
	endsequence

	sequence storeWriteS;
		memWrite && !traceClear;
	endsequence

	outsideDrop_a: assert property (outsideFetchS |-> !storeNow)
		else $error("fetch outside region was stored");

	boundInside_a: assert property (cap_reg == QTC_CAP_RUN && busValid && qualOn &&
		isProgFetch(busCycle.fc) && spaceOk(cfg_reg.space, busCycle.fc) &&
		(busCycle.addr == cfg_reg.start || busCycle.addr == cfg_reg.endBound)
		|-> storeNow)
		else $error("fetch on a region bound was not stored");

	userOnly_a: assert property (busValid && qualOn && isProgFetch(busCycle.fc) &&
		cfg_reg.space == QTC_SPC_USER && busCycle.fc[QTC_FC_SUPER_BIT]
		|-> !storeNow)
		else $error("supervisor fetch stored under user-only qualification");

	qualOff_a: assert property (cap_reg == QTC_CAP_RUN && busValid && !qualOn
		|-> storeNow)
		else $error("cycle dropped with qualification off");

	offsetEnd_a: assert property (cfgWrite && cfgEndIsOffset
		|=> cfg_reg.endBound == $past(cfgStart) + $past(cfgEnd))
		else $error("offset end bound not start plus offset");

	regionCache_a: assert property (enterRegionS |=> !cacheEnable)
		else $error("cache enabled inside region");

	goOff_a: assert property (goOffS |=> (!goCache_reg && !cacheEnable) [*2])
		else $error("cache on after run command disabled it");

	lineOff_a: assert property (!targetCacheEnable || !cacheCtrlBit0 |=> !cacheEnable)
		else $error("cache on although line or control bit disables it");

	cacheOn_a: assert property (goCache_next && targetCacheEnable && cacheCtrlBit0 &&
		!(qualOn && region_next) |=> cacheEnable)
		else $error("cache off with every control enabling it");

	resetVals_a: assert property (@(posedge clk) disable iff (1'b0)
		!resetn |=> cfg_reg.start == QTC_BOUND_RST && cfg_reg.endBound == QTC_BOUND_RST &&
		!cfg_reg.qualEn && cfg_reg.space == QTC_SPC_BOTH)
		else $error("region defaults wrong after reset");

	traceIndex_a: assert property (storeWriteS |=> wr_reg == $past(wr_reg) + 1'b1)
		else $error("trace index did not advance by one");

endmodule

`default_nettype wire

// File: verification/qtc_cpu_model.sv
// qtc_cpu_model: monitored processor bus and target cache control lines
// assumes the bench calls its tasks; everything changes at the falling edge
`timescale 1ns/1ns
`default_nettype none

module qtc_cpu_model
	import qtc_pkg::*;
(
	input wire logic clk,
	output logic busValid,
	output qtc_cycle_s busCycle,
	output logic targetCacheEnable,
	output logic cacheCtrlBit0
);
	initial begin
		busValid = 1'h0;
		busCycle = '0;
		targetCacheEnable = 1'h1;
		cacheCtrlBit0 = 1'h1;
	end

	// ----------------------------------------------------------------
	// bus traffic
	// ----------------------------------------------------------------
	// one fetch then n-1 data cycles, back to back; ignores captureReady like the real bus
	task automatic run(input logic [31:0] a, input logic [2:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			busValid = 1'h1;
			busCycle = '{addr: a + 32'(i * 4), data: a ^ 32'hA5A5_5A5A,
				fc: (i == 0) ? f : 3'h1, rw: 1'h1, strb: 4'h0};
		end
		@(negedge clk);
		busValid = 1'h0;
		// released lines show inverted data so a stale record never matches
		busCycle = ~busCycle;
	endtask

	// target hardware line and control-register bit 0
	task automatic lines(input logic t, input logic b);
		@(negedge clk);
		targetCacheEnable = t;
		cacheCtrlBit0 = b;
	endtask
endmodule

`default_nettype wire

// File: verification/tb_top.sv
// tb_top: self-checking bench for qtc_trace_gate
// assumes qtc_cpu_model stands in for the processor bus and target lines
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	import qtc_pkg::*;

	typedef struct packed {
		logic q;
		qtc_space_e s;
		logic [31:0] en;
		logic off;
		logic [31:0] a;
		logic [2:0] f;
		logic [1:0] n;
		logic inr;
	} qtc_row_s;

	logic clk, resetn, cfgWrite, cfgQualEnable, cfgEndIsOffset, spanWarn;
	logic runStart, runStop, runCacheEnable, targetCacheEnable, cacheCtrlBit0;
	logic cacheEnable, inRegion, capturing, busValid, captureReady;
	logic traceClear, traceHold, traceWrapped, overflow;
	qtc_space_e cfgSpace;
	logic [31:0] cfgStart, cfgEnd;
	logic [10:0] rdIndex, wrIndex, base;
	qtc_cycle_s busCycle, rdData;
	int err_total = 0;
	int checks = 0;

	// ----------------------------------------------------------------
	// start fixed at 100; two cycles sent per row (fetch + data)
	// ----------------------------------------------------------------
	qtc_row_s rows [11] = '{
		'{1'h0, QTC_SPC_BOTH, 32'h200, 1'h0, 32'h300, 3'h2, 2'h2, 1'h0},
		'{1'h1, QTC_SPC_BOTH, 32'h200, 1'h0, 32'h100, 3'h2, 2'h2, 1'h1},
		'{1'h1, QTC_SPC_BOTH, 32'h200, 1'h0, 32'h200, 3'h6, 2'h2, 1'h1},
		'{1'h1, QTC_SPC_BOTH, 32'h200, 1'h0, 32'h0FC, 3'h2, 2'h0, 1'h0},
		'{1'h1, QTC_SPC_BOTH, 32'h200, 1'h0, 32'h204, 3'h2, 2'h0, 1'h0},
		'{1'h1, QTC_SPC_BOTH, 32'h040, 1'h1, 32'h140, 3'h2, 2'h2, 1'h1},
		'{1'h1, QTC_SPC_BOTH, 32'h040, 1'h1, 32'h144, 3'h2, 2'h0, 1'h0},
		'{1'h1, QTC_SPC_USER, 32'h200, 1'h0, 32'h180, 3'h6, 2'h0, 1'h0},
		'{1'h1, QTC_SPC_USER, 32'h200, 1'h0, 32'h180, 3'h2, 2'h2, 1'h1},
		'{1'h1, QTC_SPC_SUPER, 32'h200, 1'h0, 32'h180, 3'h2, 2'h0, 1'h0},
		'{1'h1, QTC_SPC_SUPER, 32'h200, 1'h0, 32'h180, 3'h6, 2'h2, 1'h1}
	};

	qtc_trace_gate dut (.clk, .resetn, .cfgWrite, .cfgQualEnable, .cfgSpace, .cfgStart,
		.cfgEnd, .cfgEndIsOffset, .spanWarn, .runStart, .runStop, .runCacheEnable,
		.targetCacheEnable, .cacheCtrlBit0, .cacheEnable, .inRegion, .capturing, .busValid,
		.busCycle, .captureReady, .traceClear, .traceHold, .rdIndex, .rdData, .wrIndex,
		.traceWrapped, .overflow);

	qtc_cpu_model cpu (.clk, .busValid, .busCycle, .targetCacheEnable, .cacheCtrlBit0);

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic cfg(input logic q, input qtc_space_e s, input logic [31:0] en,
		input logic off);
		@(negedge clk);
		cfgWrite = 1'h1;
		cfgQualEnable = q;
		cfgSpace = s;
		cfgStart = 32'h100;
		cfgEnd = en;
		cfgEndIsOffset = off;
		@(negedge clk);
		cfgWrite = 1'h0;
	endtask

	task automatic go(input logic ce);
		@(negedge clk);
		runStart = 1'h1;
		runCacheEnable = ce;
		@(negedge clk);
		runStart = 1'h0;
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// stall guard: the whole sequence needs about 2300 cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		results();
	end

	initial begin
		{resetn, cfgWrite, cfgQualEnable, cfgEndIsOffset, runStart, runStop} = 6'h0;
		{runCacheEnable, traceClear, traceHold} = 3'h0;
		cfgSpace = QTC_SPC_BOTH;
		cfgStart = 32'h0;
		cfgEnd = 32'h0;
		rdIndex = 11'h0;
		idle(16);
		resetn = 1'h1;
		check("capturing", capturing, 1'h0);
		check("cacheEnable", cacheEnable, 1'h0);
		check("wrIndex", wrIndex, 11'h0);
		check("captureReady", captureReady, 1'h1);
		$display("test reset done");
		go(1'h0);
		foreach (rows[i]) begin
			cfg(rows[i].q, rows[i].s, rows[i].en, rows[i].off);
			base = wrIndex;
			cpu.run(rows[i].a, rows[i].f, 2);
			idle(4);
			check("stored", 32'(wrIndex - base), 32'(rows[i].n));
			check("inRegion", inRegion, rows[i].inr);
		end
		$display("test region table done");
		cfg(1'h0, QTC_SPC_BOTH, 32'h200, 1'h0);
		for (int i = 0; i < 8; i++) begin
			cpu.lines(i[1], i[0]);
			go(i[2]);
			idle(1);
			check("cacheEnable", cacheEnable, 32'(i[2] & i[1] & i[0]));
		end
		cfg(1'h1, QTC_SPC_BOTH, 32'h200, 1'h0);
		// end bound sits well over 12 bytes past this fetch
		cpu.run(32'h180, 3'h2, 1);
		check("cacheEnable", cacheEnable, 1'h0);
		cpu.run(32'h300, 3'h2, 1);
		check("cacheEnable", cacheEnable, 1'h1);
		$display("test cache done");
		cfg(1'h1, QTC_SPC_BOTH, 32'h113, 1'h0);
		check("spanWarn", spanWarn, 1'h1);
		cfg(1'h1, QTC_SPC_BOTH, 32'h114, 1'h0);
		check("spanWarn", spanWarn, 1'h0);
		$display("test span done");
		cfg(1'h0, QTC_SPC_BOTH, 32'h200, 1'h0);
		traceHold = 1'h1;
		base = wrIndex;
		cpu.run(32'h1000, 3'h2, 33);
		check("captureReady", captureReady, 1'h0);
		check("overflow", overflow, 1'h1);
		traceHold = 1'h0;
		rdIndex = base;
		idle(40);
		check("drained", 32'(wrIndex - base), 32'h20);
		check("rdData", rdData.addr, 32'h1000);
		$display("test fifo full done");
		traceClear = 1'h1;
		idle(1);
		traceClear = 1'h0;
		check("overflow", overflow, 1'h0);
		cpu.run(32'h2000, 3'h2, 2048);
		rdIndex = 11'h7FF;
		idle(8);
		check("wrIndex", wrIndex, 11'h0);
		check("traceWrapped", traceWrapped, 1'h1);
		check("rdData", rdData.addr, 32'h3FFC);
		$display("test wrap done");
		runStop = 1'h1;
		idle(1);
		runStop = 1'h0;
		cpu.run(32'h180, 3'h2, 1);
		idle(4);
		check("capturing", capturing, 1'h0);
		check("wrIndex", wrIndex, 11'h0);
		resetn = 1'h0;
		idle(2);
		resetn = 1'h1;
		go(1'h1);
		cpu.run(32'h5000, 3'h6, 1);
		idle(4);
		check("stored", wrIndex, 11'h1);
		// qualification is off after reset, so run enable, line and bit 0 all allow the cache
		check("cacheEnable", cacheEnable, 1'h1);
		$display("test stop and reset done");
		results();
	end
endmodule

`default_nettype wire
